// ==== common/ece_pkg.sv ====
// How it works
// - Direction bit high releases indicator, floats data.
// - Write cycle drives host byte onto port when the direction bit is low.
// - Write asserts data or address strobe.
// - Asserted hold keeps host ready low.
// - Host write release ends strobe, latches byte.
// - Read asserts strobe with port floated.
// - Host read release ends the strobe.
// - Lines may change between cycles.
// - Control strobe bit overrides write indicator.
// - Direction low unless bit set or read.
// - Peripheral interrupt passes through uninverted.
// - Data strobe for data, address strobe addresses.
// - Control bit drives peripheral reset output.
// - Registers always reachable; status bits 2 and 1 zero.
// - Watchdog aborts long cycles, flags status bit0.
// - Idle lines follow the control register.
package ece_pkg;

  // ------------------------------------------------------------
  // Host register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] OFF_DATA = 3'h0; // Shared data register.
  localparam logic [2:0] OFF_STATUS = 3'h1; // Status register.
  localparam logic [2:0] OFF_CONTROL = 3'h2; // Control register.
  localparam logic [2:0] OFF_EPP_ADDR = 3'h3; // Address cycle port.
  localparam logic [2:0] OFF_EPP_DATA0 = 3'h4; // First data cycle port.

  // ------------------------------------------------------------
  // Control and status field positions
  // ------------------------------------------------------------
  localparam int CTL_STROBE = 0; // Drives the write indicator pin.
  localparam int CTL_AUTOFD = 1; // Drives the data strobe pin.
  localparam int CTL_INIT = 2; // Peripheral reset, low asserts it.
  localparam int CTL_SELIN = 3; // Drives the address strobe pin.
  localparam int CTL_IRQEN = 4; // Passes the interrupt to the host.
  localparam int CTL_DIR = 5; // Port direction, one means input.
  localparam int STS_TMO = 0; // Watchdog timeout flag.
  localparam int STS_FAULT_N = 3; // Fault input.
  localparam int STS_SELECT = 4; // Select input.
  localparam int STS_PERROR = 5; // Paper end input.
  localparam int STS_ACK_N = 6; // Interrupt input.
  localparam int STS_BUSY_N = 7; // Inverted hold input.

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DATA_RESET = 8'h00; // Data register.
  localparam logic [7:0] CTL_RESET = 8'h00; // Control, holds reset.
  localparam logic [7:0] CTL_MASK = 8'h3F; // Top two bits read zero.

  // ------------------------------------------------------------
  // Timing and buffering
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // System clock period.
  localparam int TMO_NS = 10000; // Longest legal host cycle.
  localparam int TMO_CYCLES = TMO_NS / CLK_PERIOD_NS; // Rounded down.
  localparam int LOG_DEPTH = 32; // Transfer log depth.
  localparam int LOG_WIDTH = 10; // Write flag, address flag, byte.
  localparam int SYNC_STAGES = 2; // Hold synchroniser length.

  // Cycle engine states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_ABORT
  } ece_state_t;

endpackage

// ==== rtl/ece_sync.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Level synchroniser
// ------------------------------------------------------------
module ece_sync #(
  parameter int STAGES = 2,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  // Shift chain; only the next stage reads each flop.
  logic [STAGES-1:0] chain_reg;

  // Shifts the input along the chain while enabled.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain_reg <= {STAGES{RESET_VAL}};
    end else if (ce) begin
      chain_reg <= {chain_reg[STAGES-2:0], d};
    end
  end

  assign q = chain_reg[STAGES-1];

endmodule // ece_sync

// ==== rtl/ece_fifo.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Valid/ready FIFO
// ------------------------------------------------------------
module ece_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed.
  logic [AW:0] wr_reg; // Write pointer with wrap bit.
  logic [AW:0] rd_reg; // Read pointer with wrap bit.
  logic push;
  logic pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_reg != rd_reg;
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  assign out_data = mem[rd_reg[AW-1:0]];

  // Writes the entry under the write pointer.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // Advances the pointers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

endmodule // ece_fifo

// ==== rtl/ece_epp17_cycle_engine.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Enhanced parallel port cycle engine
// ------------------------------------------------------------
module ece_epp17_cycle_engine #(
  parameter int TMO_CYCLES = ece_pkg::TMO_CYCLES,
  parameter int LOG_DEPTH = ece_pkg::LOG_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:0] host_side_bus_in,
  output logic [7:0] host_side_bus_out,
  output logic host_side_bus_oe,
  output logic host_ready,
  output logic host_irq,
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe,
  output logic write_indicator_n,
  output logic port_direction_out,
  output logic data_phase_strobe_n,
  output logic addr_phase_strobe_n,
  input wire logic periph_hold_n,
  input wire logic periph_irq_in,
  output logic periph_reset_out_n,
  input wire logic paper_end_in,
  input wire logic select_in,
  input wire logic fault_n_in,
  output logic log_valid,
  input wire logic log_ready,
  output logic [ece_pkg::LOG_WIDTH-1:0] log_data
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    ece_pkg::ece_state_t st; // Cycle engine state.
    logic is_write; // Current cycle writes.
    logic is_addr; // Current cycle uses the address strobe.
    logic [15:0] tmo; // Watchdog count.
    logic [7:0] data; // Shared data register.
    logic [7:0] ctl; // Control register.
    logic tmo_flag; // Sticky timeout flag.
    logic [7:0] sd_out; // Byte shown to the host.
    logic rd_q; // Host read strobe, last cycle.
    logic wr_q; // Host write strobe, last cycle.
    logic [2:0] addr_q; // Address held during a host access.
    logic hold_q; // Synchronised hold, one cycle later.
    logic irq; // Registered interrupt to the host.
    logic push; // Log push request.
    logic [ece_pkg::LOG_WIDTH-1:0] push_data; // Log entry.
  } ece_regs_t;

  ece_regs_t s_reg; // Registered state.
  ece_regs_t s_next; // Next state.
  logic hold_sync; // Hold input, high when released.
  logic log_in_ready; // Log has room.
  logic host_epp; // Host addresses a cycle port.
  logic host_req; // Host strobe active on a cycle port.
  logic host_idle; // Both host strobes released.
  logic active; // A strobe is being driven.
  logic [7:0] status; // Status register view.

  // ------------------------------------------------------------
  // Leaf instances
  // ------------------------------------------------------------
  // Brings the peripheral hold line into the clock domain.
  ece_sync #(.STAGES(ece_pkg::SYNC_STAGES), .RESET_VAL(1'b1)) u_hold_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .d(periph_hold_n),
    .q(hold_sync)
  );

  // Records every completed cycle; a full log stalls the host.
  ece_fifo #(.WIDTH(ece_pkg::LOG_WIDTH), .DEPTH(LOG_DEPTH)) u_log (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(s_reg.push),
    .in_ready(log_in_ready),
    .in_data(s_reg.push_data),
    .out_valid(log_valid),
    .out_ready(log_ready),
    .out_data(log_data)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign host_epp = host_addr >= ece_pkg::OFF_EPP_ADDR;
  assign host_req = host_epp && (!host_rd_n || !host_wr_n);
  assign host_idle = host_rd_n && host_wr_n;
  assign active = s_reg.st == ece_pkg::ST_ACTIVE;

  // Status view; the two bits above the timeout flag read zero.
  always_comb begin
    status = 8'h00;
    status[ece_pkg::STS_TMO] = s_reg.tmo_flag;
    status[ece_pkg::STS_FAULT_N] = fault_n_in;
    status[ece_pkg::STS_SELECT] = select_in;
    status[ece_pkg::STS_PERROR] = paper_end_in;
    status[ece_pkg::STS_ACK_N] = periph_irq_in;
    status[ece_pkg::STS_BUSY_N] = !periph_hold_n;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Computes the engine, register and host read path updates.
  always_comb begin
    s_next = s_reg;
    s_next.rd_q = host_rd_n;
    s_next.wr_q = host_wr_n;
    s_next.hold_q = hold_sync;
    s_next.push = 1'b0;
    s_next.irq = periph_irq_in && s_reg.ctl[ece_pkg::CTL_IRQEN];
    if (!host_idle) begin
      s_next.addr_q = host_addr;
    end
    // Host read path, usable in every port mode.
    case (host_addr)
      ece_pkg::OFF_DATA: begin
        s_next.sd_out = s_reg.ctl[ece_pkg::CTL_DIR] ? port_data_lines_in : s_reg.data;
      end
      ece_pkg::OFF_STATUS: begin
        s_next.sd_out = status;
      end
      ece_pkg::OFF_CONTROL: begin
        s_next.sd_out = s_reg.ctl & ece_pkg::CTL_MASK;
      end
      default: begin
        s_next.sd_out = s_reg.sd_out;
      end
    endcase
    // Plain register writes take effect when the host strobe ends.
    if (!s_reg.wr_q && host_wr_n && s_reg.st == ece_pkg::ST_IDLE) begin
      case (s_reg.addr_q)
        ece_pkg::OFF_DATA: begin
          s_next.data = host_side_bus_in;
        end
        ece_pkg::OFF_CONTROL: begin
          s_next.ctl = host_side_bus_in & ece_pkg::CTL_MASK;
        end
        default: begin
          s_next.data = s_reg.data;
        end
      endcase
    end
    // Reading the status clears the timeout flag once the read ends.
    if (!s_reg.rd_q && host_rd_n && s_reg.addr_q == ece_pkg::OFF_STATUS) begin
      s_next.tmo_flag = 1'b0;
    end
    case (s_reg.st)
      // Waits for a cycle port access and room in the log.
      ece_pkg::ST_IDLE: begin
        s_next.tmo = 16'h0000;
        if (host_req && log_in_ready) begin
          s_next.st = ece_pkg::ST_ACTIVE;
          s_next.is_write = !host_wr_n;
          s_next.is_addr = host_addr == ece_pkg::OFF_EPP_ADDR;
          if (!host_wr_n) begin
            s_next.data = host_side_bus_in;
          end
        end
      end
      // Strobe asserted; ends on host release or watchdog expiry.
      ece_pkg::ST_ACTIVE: begin
        s_next.tmo = s_reg.tmo + 16'h0001;
        if (!s_reg.is_write && hold_sync) begin
          s_next.sd_out = port_data_lines_in;
        end
        if (host_idle) begin
          s_next.st = ece_pkg::ST_IDLE;
          s_next.push = 1'b1;
          s_next.push_data = {s_reg.is_write, s_reg.is_addr,
                              s_reg.is_write ? host_side_bus_in : s_reg.sd_out};
          if (s_reg.is_write) begin
            s_next.data = host_side_bus_in;
          end
        end else if (s_reg.tmo == 16'(TMO_CYCLES - 1)) begin
          s_next.st = ece_pkg::ST_ABORT;
          s_next.tmo_flag = 1'b1;
        end
      end
      // Aborted; the strobe is gone, wait for the host to let go.
      ece_pkg::ST_ABORT: begin
        if (host_idle) begin
          s_next.st = ece_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = ece_pkg::ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Holds all state; a low clock enable freezes it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= ece_pkg::ST_IDLE;
      s_reg.data <= ece_pkg::DATA_RESET;
      s_reg.ctl <= ece_pkg::CTL_RESET;
      s_reg.rd_q <= 1'b1;
      s_reg.wr_q <= 1'b1;
      s_reg.hold_q <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Host sees its byte whenever it reads this block.
  assign host_side_bus_out = s_reg.sd_out;
  assign host_side_bus_oe = !host_rd_n;
  assign host_irq = s_reg.irq;

  // Ready drops for a pending cycle with no log room and while held. The first two
  // edges of a cycle hold it low as well, so that a release still in the synchroniser
  // from the previous cycle is never taken as the answer to this one.
  assign host_ready = !((host_req && s_reg.st == ece_pkg::ST_IDLE && !log_in_ready)
                      || (active && !(hold_sync && s_reg.hold_q
                                      && s_reg.tmo >= 16'h0002)));

  // Direction follows the control bit, and goes to input for reads.
  assign port_direction_out = s_reg.ctl[ece_pkg::CTL_DIR]
                              || (active && !s_reg.is_write);
  assign port_data_lines_oe = !port_direction_out;
  assign port_data_lines_out = s_reg.data;

  // The control strobe bit forces the write indicator low at all times.
  assign write_indicator_n = !s_reg.ctl[ece_pkg::CTL_STROBE]
                             && (active ? !s_reg.is_write
                                        : s_reg.ctl[ece_pkg::CTL_DIR]);

  // Strobes follow the cycle, or the control bits when idle.
  assign data_phase_strobe_n = active ? s_reg.is_addr
                                      : !s_reg.ctl[ece_pkg::CTL_AUTOFD];
  assign addr_phase_strobe_n = active ? !s_reg.is_addr
                                      : !s_reg.ctl[ece_pkg::CTL_SELIN];
  assign periph_reset_out_n = s_reg.ctl[ece_pkg::CTL_INIT];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n || !ce);

  // A strobe only starts in answer to a host strobe.
  property p_strobe_cause;
    $fell(data_phase_strobe_n && addr_phase_strobe_n) && active
      |-> $past(!host_rd_n || !host_wr_n);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without host");

  // Host release ends the strobe on the next edge when the idle strobe bits are clear.
  property p_release;
    active && host_idle && !s_reg.ctl[ece_pkg::CTL_AUTOFD] && !s_reg.ctl[ece_pkg::CTL_SELIN]
      |=> data_phase_strobe_n && addr_phase_strobe_n;
  endproperty
  a_release: assert property (p_release) else $error("strobe not released");

  // Held peripheral keeps the host waiting.
  property p_hold;
    active && !hold_sync |-> !host_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("ready while held");

  // Write cycles with direction low drive the latched host byte.
  property p_write_drive;
    active && s_reg.is_write && !s_reg.ctl[ece_pkg::CTL_DIR]
      |-> port_data_lines_oe && port_data_lines_out == $past(host_side_bus_in);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write byte wrong");

  // Read cycles float the port and show input direction.
  property p_read_float;
    active && !s_reg.is_write |-> !port_data_lines_oe && port_direction_out;
  endproperty
  a_read_float: assert property (p_read_float) else $error("read not floated");

  // The watchdog aborts and flags after the exact count.
  property p_watchdog;
    active && !host_idle && s_reg.tmo == 16'(TMO_CYCLES - 1)
      |=> status[ece_pkg::STS_TMO] && data_phase_strobe_n && addr_phase_strobe_n;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog missed");

  // Status reads show zero in bits two and one.
  property p_status_low;
    !host_rd_n && host_addr == ece_pkg::OFF_STATUS ##1 !host_rd_n
      |-> host_side_bus_out[2:1] == 2'b00;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits set");

  // Idle direction follows the control bit alone.
  property p_direction;
    !active |-> port_direction_out == s_reg.ctl[ece_pkg::CTL_DIR];
  endproperty
  a_direction: assert property (p_direction) else $error("direction wrong");

  // Control strobe bit always wins on the write indicator.
  property p_override;
    s_reg.ctl[ece_pkg::CTL_STROBE] |-> !write_indicator_n;
  endproperty
  a_override: assert property (p_override) else $error("override lost");

  // Interrupt follows the input one cycle later when enabled.
  property p_irq;
    s_reg.ctl[ece_pkg::CTL_IRQEN] && $stable(s_reg.ctl) |=> host_irq == $past(periph_irq_in);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not passed");

  // Idle with direction low asserts the write indicator.
  property p_idle_write;
    !active && !s_reg.ctl[ece_pkg::CTL_DIR] |-> !write_indicator_n;
  endproperty
  a_idle_write: assert property (p_idle_write) else $error("indicator not low");

  c_write: cover property (active && s_reg.is_write && host_idle);
  c_read: cover property (active && !s_reg.is_write && host_idle);
  c_abort: cover property (s_reg.st == ece_pkg::ST_ABORT);
  c_full: cover property (host_req && !log_in_ready);

endmodule // ece_epp17_cycle_engine

// ==== sim/ece_periph_model.sv ====
`timescale 1ns/100ps
// --------
// Byte-wide peripheral with a hold handshake
// --------
module ece_periph_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic data_phase_strobe_n,
  input wire logic addr_phase_strobe_n,
  input wire logic port_direction_out,
  input wire logic [7:0] port_data_lines_out,
  input wire logic port_data_lines_oe,
  input wire logic [15:0] hold_cycles,
  input wire logic [7:0] reply_byte,
  output logic [7:0] port_data_lines_in,
  output logic periph_hold_n
);
  logic active; // Some strobe is asserted.
  logic drive_reg; // The model drives the port.
  logic [15:0] count_reg; // Edges since the strobe fell.
  logic [7:0] last_reg; // Last level seen on the port.

  assign active = !(data_phase_strobe_n && addr_phase_strobe_n);

  // Resolves the shared port; undriven lines change every cycle.
  always_comb begin
    if (port_data_lines_oe) begin
      port_data_lines_in = port_data_lines_out;
    end else if (drive_reg) begin
      port_data_lines_in = reply_byte;
    end else begin
      port_data_lines_in = ~last_reg;
    end
  end

  // Answers a strobe after a set delay, then makes ready for the next one.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
      drive_reg <= 1'b0;
      periph_hold_n <= 1'b0;
      last_reg <= 8'h00;
    end else begin
      last_reg <= port_data_lines_in;
      if (active) begin
        count_reg <= count_reg + 16'h0001;
        drive_reg <= port_direction_out;
        periph_hold_n <= (count_reg >= hold_cycles);
      end else begin
        count_reg <= 16'h0000;
        drive_reg <= 1'b0;
        periph_hold_n <= 1'b0;
      end
    end
  end
endmodule // ece_periph_model

// ==== sim/ece_epp17_cycle_engine_tb.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// --------
// Bench top
// --------
module ece_epp17_cycle_engine_tb;
  localparam int TMO = 20; // Short watchdog count.
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic host_rd_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic [7:0] host_side_bus_in = 8'h00;
  logic [7:0] host_side_bus_out, port_data_lines_in, port_data_lines_out, rd_q, snap_pd;
  logic host_side_bus_oe, host_ready, host_irq, port_data_lines_oe, write_indicator_n;
  logic port_direction_out, data_phase_strobe_n, addr_phase_strobe_n, periph_hold_n;
  logic periph_reset_out_n, log_valid, seen, end_strb;
  logic periph_irq_in = 1'b0;
  logic [2:0] sts_in = 3'h5; // Paper end, select, fault levels.
  logic log_ready = 1'b0;
  logic [9:0] log_data;
  logic [15:0] hold_cycles = 16'h0003; // Peripheral answer delay.
  logic [7:0] reply_byte = 8'hC3; // Byte the peripheral returns.
  logic [4:0] snap; // Write flag, direction, enable, strobes at first strobe.
  int failures = 0;
  int n_tests = 0;
  int wcnt; // Edges with host_ready low.

  always #5 clock = ~clock;

  ece_epp17_cycle_engine #(.TMO_CYCLES(TMO), .LOG_DEPTH(32)) DUT (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .host_addr(host_addr),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_side_bus_in(host_side_bus_in),
    .host_side_bus_out(host_side_bus_out), .host_side_bus_oe(host_side_bus_oe),
    .host_ready(host_ready), .host_irq(host_irq), .port_data_lines_in(port_data_lines_in),
    .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
    .write_indicator_n(write_indicator_n), .port_direction_out(port_direction_out),
    .data_phase_strobe_n(data_phase_strobe_n), .addr_phase_strobe_n(addr_phase_strobe_n),
    .periph_hold_n(periph_hold_n), .periph_irq_in(periph_irq_in),
    .periph_reset_out_n(periph_reset_out_n), .paper_end_in(sts_in[2]),
    .select_in(sts_in[1]), .fault_n_in(sts_in[0]), .log_valid(log_valid),
    .log_ready(log_ready), .log_data(log_data));

  ece_periph_model PERIPH (
    .clock(clock), .rst_n(rst_n), .data_phase_strobe_n(data_phase_strobe_n),
    .addr_phase_strobe_n(addr_phase_strobe_n), .port_direction_out(port_direction_out),
    .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
    .hold_cycles(hold_cycles), .reply_byte(reply_byte),
    .port_data_lines_in(port_data_lines_in), .periph_hold_n(periph_hold_n));

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One host access held until ready; snapshots the port at the first strobe.
  task automatic cyc(input logic [2:0] a, input logic rd, input logic [7:0] d);
    int n;
    n = 0;
    wcnt = 0;
    seen = 1'b0;
    host_addr = a;
    host_side_bus_in = d;
    host_rd_n = !rd;
    host_wr_n = rd;
    @(posedge clock);
    do begin
      @(posedge clock);
      n++;
      if (!host_ready) wcnt++;
      if (!seen && !(data_phase_strobe_n && addr_phase_strobe_n)) begin
        seen = 1'b1;
        snap = {write_indicator_n, port_direction_out, port_data_lines_oe,
                data_phase_strobe_n, addr_phase_strobe_n};
        snap_pd = port_data_lines_out;
      end
    end while (!host_ready && n < 300);
    rd_q = host_side_bus_out;
    end_strb = data_phase_strobe_n && addr_phase_strobe_n;
    `CHK(host_side_bus_oe, rd)
    if (n >= 300) begin
      failures++;
      test_done();
    end
    #1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Pops one log entry, waiting a bounded time for it.
  task automatic pop(input logic [9:0] exp);
    int n;
    n = 0;
    while (!log_valid && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    log_ready = 1'b1;
    @(posedge clock);
    `CHK(log_valid, 1'b1)
    `CHK(log_data, exp)
    #1 log_ready = 1'b0;
  endtask

  // Reset levels, status layout and control register effects.
  task automatic sc_regs();
    `CHK(periph_reset_out_n, 1'b0)
    `CHK({write_indicator_n, port_direction_out, data_phase_strobe_n}, 3'h1)
    cyc(ece_pkg::OFF_STATUS, 1'b1, 8'h00);
    `CHK(rd_q, 8'hA8)
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'hFF);
    cyc(ece_pkg::OFF_CONTROL, 1'b1, 8'h00);
    `CHK(rd_q, ece_pkg::CTL_MASK)
    `CHK({periph_reset_out_n, port_direction_out, port_data_lines_oe}, 3'h6)
    `CHK({data_phase_strobe_n, addr_phase_strobe_n, write_indicator_n}, 3'h0)
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h04);
    cyc(ece_pkg::OFF_DATA, 1'b0, 8'h3C);
    `CHK({port_data_lines_oe, port_data_lines_out}, 9'h13C)
  endtask

  // Data and address writes, then reads with a slow peripheral.
  task automatic sc_cycles();
    cyc(ece_pkg::OFF_EPP_DATA0, 1'b0, 8'hA5);
    `CHK(snap, 5'b00101)
    `CHK({snap_pd, end_strb}, 9'h14A)
    `CHK({data_phase_strobe_n, wcnt >= 3}, 2'h3)
    pop({2'b10, 8'hA5});
    cyc(ece_pkg::OFF_EPP_ADDR, 1'b0, 8'h5A);
    `CHK(snap, 5'b00110)
    pop({2'b11, 8'h5A});
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h24);
    hold_cycles = 16'h000A;
    cyc(ece_pkg::OFF_EPP_DATA0, 1'b1, 8'h00);
    `CHK(snap, 5'b11001)
    `CHK({rd_q, wcnt >= 10}, 9'h187)
    `CHK({data_phase_strobe_n, addr_phase_strobe_n}, 2'h3)
    pop({2'b00, 8'hC3});
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h25);
    cyc(ece_pkg::OFF_EPP_ADDR, 1'b1, 8'h00);
    `CHK(snap[4], 1'b0)
    pop({2'b01, 8'hC3});
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h04);
    hold_cycles = 16'h0003;
  endtask

  // Silent peripheral trips the watchdog; the flag clears after one read.
  task automatic sc_timeout();
    hold_cycles = 16'hFFFF;
    cyc(ece_pkg::OFF_EPP_DATA0, 1'b0, 8'h11);
    `CHK({end_strb, wcnt >= TMO - 1 && wcnt <= TMO + 1, log_valid}, 3'h6)
    cyc(ece_pkg::OFF_STATUS, 1'b1, 8'h00);
    `CHK(rd_q[2:0], 3'h1)
    cyc(ece_pkg::OFF_STATUS, 1'b1, 8'h00);
    `CHK(rd_q[2:0], 3'h0)
    hold_cycles = 16'h0003;
  endtask

  // Interrupt passes through uninverted while enabled, then drops with the input low and the enable bit cleared.
  task automatic sc_irq();
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h14);
    periph_irq_in = 1'b1;
    cyc(ece_pkg::OFF_STATUS, 1'b1, 8'h00);
    `CHK({host_irq, rd_q[6]}, 2'h3)
    periph_irq_in = 1'b0;
    cyc(ece_pkg::OFF_CONTROL, 1'b0, 8'h04);
    `CHK(host_irq, 1'b0)
  endtask

  // Fills the log until a cycle is held off, then drains it in order.
  task automatic sc_fifo();
    for (int i = 0; i < 32; i++) cyc(ece_pkg::OFF_EPP_DATA0, 1'b0, 8'(i));
    fork
      cyc(ece_pkg::OFF_EPP_DATA0, 1'b0, 8'hEE);
      begin
        repeat (8) @(posedge clock);
        `CHK({host_ready, data_phase_strobe_n}, 2'h1)
        #1 log_ready = 1'b1;
        @(posedge clock);
        #1 log_ready = 1'b0;
      end
    join
    for (int i = 1; i < 32; i++) pop({2'b10, 8'(i)});
    pop({2'b10, 8'hEE});
    `CHK(log_valid, 1'b0)
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock);
    #1;
    sc_regs();
    sc_cycles();
    sc_timeout();
    sc_irq();
    sc_fifo();
    test_done();
  end
endmodule // ece_epp17_cycle_engine_tb
